//--- design/pin_event_detect.sv
// Level and edge detector for one pin.
`timescale 1ns/100ps
`include "port_pin_cfg.svh"

module pin_event_detect
(
    // Configuration
    input wire logic enable_in,
    input wire logic [3:0] cfg_in,
    // Samples
    input wire logic level_in,
    input wire logic last_in,
    // Result
    output logic hit_out
);

    logic rise;
    logic fall;

    assign rise = level_in & ~last_in;
    assign fall = ~level_in & last_in;

    always_comb
    begin
        hit_out = 1'b0;
        if (enable_in)
        begin
            case (cfg_in)
                `EV_DMA_RISE, `EV_IRQ_RISE: hit_out = rise;
                `EV_DMA_FALL, `EV_IRQ_FALL: hit_out = fall;
                `EV_DMA_BOTH, `EV_IRQ_BOTH: hit_out = rise | fall;
                `EV_IRQ_LOW: hit_out = ~level_in;
                `EV_IRQ_HIGH: hit_out = level_in;
                default: hit_out = 1'b0;
            endcase
        end
    end

endmodule : pin_event_detect

//--- design/port_pin_control.sv
// Port pin-control unit: 32 pin configuration registers, bulk writes, pin events, AHB-Lite.
//
// What this block does
// - Upper bulk mask selects pins 16 to 31.
// - Bulk value copied to every selected lower half.
// - Event flag register has one bit per pin.
// - Flags of non-event pins are read-only.
// - One shared flag, clearable in both places.
// - DMA completion clears flags of DMA pins.
// - Other flags clear only on written one.
// - Active level sets flag again after clear.
// - Upper half events, lower half pad settings.
// - Pad settings hold in every digital mux.
// - Analog mux disables pull and filter.
// - Configuration kept while port is disabled.
// - Bulk writes never touch event configuration.
// - Bulk registers are write-only, read zero.
// - Detection works only while port enabled.
// - Nine event modes, disabled after reset.
// - Pins synchronised before detection outside Stop.
// - One interrupt while any interrupt flag set.
// - One DMA request while any DMA flag set.
// - Stop mode detects directly and raises wakeup.
// - Four-bit event codes, others reserved.
// - Mux code zero analog, one general I/O.
// - Lower bulk mask selects pins 0 to 15.
`timescale 1ns/100ps
`include "port_pin_cfg.svh"

module port_pin_control
#(
    // Pins able to raise events; the default marks all 32.
    parameter logic [31:0] EVENT_PIN_MASK = 32'hffff_ffff
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // System
    input wire logic port_enable_in,
    input wire logic stop_mode_in,
    input wire logic dma_done_in,
    // Pins
    input wire logic [31:0] pin_in,
    // Requests
    output logic irq_out,
    output logic dma_req_out,
    output logic wakeup_out,
    // Pad configuration
    output logic [31:0] pull_enable_out,
    output logic [31:0] pull_select_out,
    output logic [31:0] drive_high_out,
    output logic [31:0] slew_slow_out,
    output logic [31:0] filter_enable_out,
    output logic [95:0] mux_select_out
);

    import port_pin_pkg::*;

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    function automatic logic is_dma_mode(input logic [3:0] cfg);
        is_dma_mode = (cfg == `EV_DMA_RISE) || (cfg == `EV_DMA_FALL) ||
                      (cfg == `EV_DMA_BOTH);
    endfunction : is_dma_mode

    function automatic logic is_irq_mode(input logic [3:0] cfg);
        is_irq_mode = (cfg == `EV_IRQ_LOW) || (cfg == `EV_IRQ_RISE) ||
                      (cfg == `EV_IRQ_FALL) || (cfg == `EV_IRQ_BOTH) ||
                      (cfg == `EV_IRQ_HIGH);
    endfunction : is_irq_mode

    function automatic logic is_bulk(input logic [7:0] addr);
        is_bulk = (addr == `OFS_LOWER_BULK) || (addr == `OFS_UPPER_BULK);
    endfunction : is_bulk

    localparam ctrl_state_type STATE_RESET = '{
        bus_state: BUS_IDLE,
        hready: 1'b1,
        evcfg: {32{`EV_OFF}},
        lo: {32{`PCR_LO_RESET}},
        default: '0
    };

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n_sync;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n_sync = rst_sync_q[1];

    // ------------------------------------------------------------------------
    // Per-pin decoding and detection
    // ------------------------------------------------------------------------
    ctrl_state_type s_q;
    ctrl_state_type s_d;
    logic [31:0] hit_vec;
    logic [31:0] irq_vec;
    logic [31:0] dma_vec;
    logic [31:0] nz_vec;
    logic [31:0] pe_vec;
    logic [31:0] clr_vec;

    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1)
        begin : g_pin
            assign irq_vec[g] = is_irq_mode(s_q.evcfg[g]);
            assign dma_vec[g] = is_dma_mode(s_q.evcfg[g]);
            // Mux code zero is the analog or disabled slot.
            assign nz_vec[g] = s_q.lo[g][`PCR_MUX_MSB:`PCR_MUX_LSB] != `MUX_ANALOG;
            assign pe_vec[g] = s_q.lo[g][`PCR_PE_BIT];
            pin_event_detect u_detect
            (
                .enable_in(port_enable_in & nz_vec[g] & EVENT_PIN_MASK[g]),
                .cfg_in(s_q.evcfg[g]),
                // Stop mode watches the raw pin; otherwise the synchronised copy.
                .level_in(stop_mode_in ? pin_in[g] : s_q.sync2[g]),
                .last_in(stop_mode_in ? s_q.raw_last[g] : s_q.last[g]),
                .hit_out(hit_vec[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        clr_vec = '0;
        unique case (s_q.bus_state)
            BUS_IDLE:
            begin
                s_d.bus_state = BUS_IDLE;
            end
            BUS_WRITE:
            begin
                // Narrower writes are dropped, bulk registers above all.
                if (s_q.word_ok)
                begin
                    if (s_q.addr < `OFS_PCR_LIMIT)
                    begin
                        s_d.lo[s_q.addr[6:2]] = hwdata_in[15:0] & `PCR_LO_MASK;
                        if (EVENT_PIN_MASK[s_q.addr[6:2]])
                        begin
                            s_d.evcfg[s_q.addr[6:2]] =
                                hwdata_in[`PCR_EVCFG_MSB:`PCR_EVCFG_LSB];
                            clr_vec[s_q.addr[6:2]] = hwdata_in[`PCR_FLAG_BIT];
                        end
                    end
                    else if (is_bulk(s_q.addr))
                    begin
                        for (int i = 0; i < `BULK_HALF; i++)
                        begin
                            if (hwdata_in[`BULK_HALF + i])
                            begin
                                if (s_q.addr == `OFS_UPPER_BULK)
                                begin
                                    s_d.lo[`BULK_HALF + i] = hwdata_in[15:0] & `PCR_LO_MASK;
                                end
                                else
                                begin
                                    s_d.lo[i] = hwdata_in[15:0] & `PCR_LO_MASK;
                                end
                            end
                        end
                    end
                    else if (s_q.addr == `OFS_EVENT_FLAGS)
                    begin
                        clr_vec = hwdata_in;
                    end
                end
                s_d.bus_state = BUS_IDLE;
            end
            BUS_READ:
            begin
                if (s_q.addr < `OFS_PCR_LIMIT)
                begin
                    s_d.hrdata = {7'h00, s_q.flag[s_q.addr[6:2]], 4'h0,
                                  s_q.evcfg[s_q.addr[6:2]], s_q.lo[s_q.addr[6:2]]};
                end
                else if (s_q.addr == `OFS_EVENT_FLAGS)
                begin
                    s_d.hrdata = s_q.flag;
                end
                else
                begin
                    // Bulk and unmapped words read as zero.
                    s_d.hrdata = `RD_ZERO;
                end
                s_d.hready = 1'b1;
                s_d.bus_state = BUS_IDLE;
            end
            default:
            begin
                s_d.hready = 1'b1;
                s_d.bus_state = BUS_IDLE;
            end
        endcase

        // A new address phase is taken only while the slave is ready.
        if (s_q.hready && hready_in && hsel_in && htrans_in[`HTRANS_ACTIVE_BIT])
        begin
            s_d.addr = {haddr_in[7:2], 2'b00};
            s_d.word_ok = hsize_in == `HSIZE_WORD;
            if (hwrite_in)
            begin
                s_d.bus_state = BUS_WRITE;
            end
            else
            begin
                s_d.bus_state = BUS_READ;
                s_d.hready = 1'b0;
            end
        end

        // Sampling chain and edge history.
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.last = s_q.sync2;
        s_d.raw_last = pin_in;

        // A detection in the clearing cycle wins, which also re-arms active levels.
        s_d.flag = EVENT_PIN_MASK & ((s_q.flag & ~clr_vec &
                   ~(dma_done_in ? dma_vec : 32'h0000_0000)) | hit_vec);

        s_d.irq = |(s_q.flag & irq_vec);
        s_d.dma = |(s_q.flag & dma_vec);
        s_d.wake = stop_mode_in & (s_q.wake | (|hit_vec));

        // Pad settings come only from the registers, never from a peripheral.
        s_d.pull_en = pe_vec & nz_vec;
        for (int i = 0; i < 32; i++)
        begin
            s_d.pull_sel[i] = s_q.lo[i][`PCR_PS_BIT];
            s_d.drive[i] = s_q.lo[i][`PCR_DSE_BIT];
            s_d.slew[i] = s_q.lo[i][`PCR_SRE_BIT];
            s_d.filter[i] = s_q.lo[i][`PCR_PFE_BIT] & nz_vec[i];
            s_d.mux[i] = s_q.lo[i][`PCR_MUX_MSB:`PCR_MUX_LSB];
        end
    end

    // Configuration is reset only by the system reset, not by port disable.
    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            s_q <= STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hrdata_out = s_q.hrdata;
    assign hreadyout_out = s_q.hready;
    assign hresp_out = 1'b0;
    assign irq_out = s_q.irq;
    assign dma_req_out = s_q.dma;
    assign wakeup_out = s_q.wake;
    assign pull_enable_out = s_q.pull_en;
    assign pull_select_out = s_q.pull_sel;
    assign drive_high_out = s_q.drive;
    assign slew_slow_out = s_q.slew;
    assign filter_enable_out = s_q.filter;
    assign mux_select_out = s_q.mux;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    logic bulk_commit;
    assign bulk_commit = (s_q.bus_state == BUS_WRITE) && is_bulk(s_q.addr);

    property p_irq_follows;
        @(posedge clk_in) disable iff (!rst_n_sync)
        ##1 irq_out == $past(|(s_q.flag & irq_vec));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq does not track flags");

    property p_dma_follows;
        @(posedge clk_in) disable iff (!rst_n_sync)
        ##1 dma_req_out == $past(|(s_q.flag & dma_vec));
    endproperty
    a_dma_follows: assert property (p_dma_follows) else $error("dma does not track flags");

    property p_bulk_keeps_event;
        @(posedge clk_in) disable iff (!rst_n_sync)
        bulk_commit |=> (s_q.evcfg == $past(s_q.evcfg)) && (s_q.flag & ~$past(hit_vec)) ==
                        ($past(s_q.flag) & ~$past(hit_vec) & ~($past(dma_done_in) ? $past(dma_vec) : '0));
    endproperty
    a_bulk_keeps_event: assert property (p_bulk_keeps_event) else $error("bulk write hit events");

    property p_bulk_reads_zero;
        @(posedge clk_in) disable iff (!rst_n_sync)
        (s_q.bus_state == BUS_READ && is_bulk(s_q.addr)) |=> hreadyout_out && hrdata_out == '0;
    endproperty
    a_bulk_reads_zero: assert property (p_bulk_reads_zero) else $error("bulk read not zero");

    property p_noncap_flag;
        @(posedge clk_in) disable iff (!rst_n_sync)
        (s_q.flag & ~EVENT_PIN_MASK) == '0;
    endproperty
    a_noncap_flag: assert property (p_noncap_flag) else $error("flag on non-event pin");

    property p_hit_sets_flag;
        @(posedge clk_in) disable iff (!rst_n_sync)
        (|(hit_vec & EVENT_PIN_MASK)) |=>
            ((s_q.flag & $past(hit_vec & EVENT_PIN_MASK)) == $past(hit_vec & EVENT_PIN_MASK));
    endproperty
    a_hit_sets_flag: assert property (p_hit_sets_flag) else $error("detection lost");

    property p_analog_pull_off;
        @(posedge clk_in) disable iff (!rst_n_sync)
        ##1 pull_enable_out == $past(pe_vec & nz_vec) && (filter_enable_out & ~$past(nz_vec)) == '0;
    endproperty
    a_analog_pull_off: assert property (p_analog_pull_off) else $error("pull on analog pin");

    property p_wake_only_stop;
        @(posedge clk_in) disable iff (!rst_n_sync)
        !stop_mode_in |=> !wakeup_out;
    endproperty
    a_wake_only_stop: assert property (p_wake_only_stop) else $error("wakeup outside stop");

    property p_dma_clear;
        @(posedge clk_in) disable iff (!rst_n_sync)
        (dma_done_in && hit_vec == '0) |=> (s_q.flag & $past(dma_vec)) == '0 ##1 !dma_req_out;
    endproperty
    a_dma_clear: assert property (p_dma_clear) else $error("dma flag not cleared");

    property p_read_wait;
        @(posedge clk_in) disable iff (!rst_n_sync)
        (s_q.bus_state == BUS_READ) |-> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

    c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_sync) $rose(irq_out));
    c_dma: cover property (@(posedge clk_in) disable iff (!rst_n_sync) $rose(dma_req_out));
    c_wake: cover property (@(posedge clk_in) disable iff (!rst_n_sync) $rose(wakeup_out));
    c_bulk: cover property (@(posedge clk_in) disable iff (!rst_n_sync) bulk_commit);

endmodule : port_pin_control

//--- pkg/port_pin_cfg.svh
// Offsets, field positions, codes and reset values of the port pin-control block.
`ifndef PORT_PIN_CFG_SVH
`define PORT_PIN_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define OFS_PCR_LIMIT 8'h80
`define OFS_LOWER_BULK 8'h80
`define OFS_UPPER_BULK 8'h84
`define OFS_EVENT_FLAGS 8'ha0

// ----------------------------------------------------------------------------
// Pin configuration register fields
// ----------------------------------------------------------------------------
`define PCR_FLAG_BIT 24
`define PCR_EVCFG_MSB 19
`define PCR_EVCFG_LSB 16
`define PCR_MUX_MSB 10
`define PCR_MUX_LSB 8
`define PCR_DSE_BIT 6
`define PCR_PFE_BIT 4
`define PCR_SRE_BIT 2
`define PCR_PE_BIT 1
`define PCR_PS_BIT 0
`define PCR_LO_MASK 16'h0757
`define PCR_LO_RESET 16'h0000
`define MUX_ANALOG 3'h0
`define BULK_HALF 16

// ----------------------------------------------------------------------------
// Pin event configuration codes
// ----------------------------------------------------------------------------
`define EV_OFF 4'h0
`define EV_DMA_RISE 4'h1
`define EV_DMA_FALL 4'h2
`define EV_DMA_BOTH 4'h3
`define EV_IRQ_LOW 4'h8
`define EV_IRQ_RISE 4'h9
`define EV_IRQ_FALL 4'ha
`define EV_IRQ_BOTH 4'hb
`define EV_IRQ_HIGH 4'hc

// ----------------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------------
`define HSIZE_WORD 3'h2
`define HTRANS_ACTIVE_BIT 1
`define RD_ZERO 32'h0000_0000

`endif

//--- pkg/port_pin_pkg.sv
// Types shared by the port pin-control block.
package port_pin_pkg;

    // ------------------------------------------------------------------------
    // Bus slave phases
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_state_type;

    // ------------------------------------------------------------------------
    // Whole state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed {
        bus_state_type bus_state;
        logic [7:0] addr;
        logic word_ok;
        logic hready;
        logic [31:0] hrdata;
        logic [31:0][15:0] lo;
        logic [31:0][3:0] evcfg;
        logic [31:0] flag;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] last;
        logic [31:0] raw_last;
        logic irq;
        logic dma;
        logic wake;
        logic [31:0] pull_en;
        logic [31:0] pull_sel;
        logic [31:0] drive;
        logic [31:0] slew;
        logic [31:0] filter;
        logic [31:0][2:0] mux;
    } ctrl_state_type;

endpackage : port_pin_pkg

//--- testbench/pin_side_model.sv
// Model of the pins and the DMA engine that face the port block.
`timescale 1ns/100ps

module pin_side_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bench controls
    input wire logic [31:0] level_in,
    input wire logic [7:0] dma_delay_in,
    // Port side
    input wire logic dma_req_in,
    output logic [31:0] pin_out,
    output logic dma_done_out
);
    logic [7:0] wait_q;

    // A delay of zero keeps the DMA engine from answering at all.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pin_out <= 32'h0000_0000;
            wait_q <= 8'h00;
            dma_done_out <= 1'b0;
        end
        else
        begin
            pin_out <= level_in;
            dma_done_out <= 1'b0;
            if (!dma_req_in || dma_delay_in == 8'h00)
                wait_q <= 8'h00;
            else if (wait_q == dma_delay_in)
            begin
                dma_done_out <= 1'b1;
                wait_q <= 8'h00;
            end
            else
                wait_q <= wait_q + 8'h01;
        end
    end
endmodule : pin_side_model

//--- testbench/port_pin_control_tb.sv
// Self-checking bench for the port pin-control block.
`timescale 1ns/100ps
`include "port_pin_cfg.svh"

module port_pin_control_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [2:0] hsize_in = 3'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic port_enable_in = 1'b0;
    logic stop_mode_in = 1'b0;
    logic [31:0] level = 32'h0;
    logic [7:0] dma_delay = 8'h00;
    logic [31:0] pin_in, hrdata_out, pull_enable_out, pull_select_out;
    logic [31:0] drive_high_out, slew_slow_out, filter_enable_out;
    logic [95:0] mux_select_out;
    logic hreadyout_out, hresp_out, irq_out, dma_req_out, wakeup_out, dma_done_in;
    logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h4};
    int errors = 0;
    int total_checks = 0;

    always #20 clk_in = ~clk_in;

    // Pin 31 cannot raise events.
    port_pin_control #(.EVENT_PIN_MASK(32'h7fff_ffff)) i_port_pin_control (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .port_enable_in(port_enable_in), .stop_mode_in(stop_mode_in),
        .dma_done_in(dma_done_in), .pin_in(pin_in), .irq_out(irq_out),
        .dma_req_out(dma_req_out), .wakeup_out(wakeup_out),
        .pull_enable_out(pull_enable_out), .pull_select_out(pull_select_out),
        .drive_high_out(drive_high_out), .slew_slow_out(slew_slow_out),
        .filter_enable_out(filter_enable_out), .mux_select_out(mux_select_out));

    pin_side_model i_pin_side_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .level_in(level), .dma_delay_in(dma_delay), .dma_req_in(dma_req_out),
        .pin_out(pin_in), .dma_done_out(dma_done_in));

    // ------------------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------------------
    task print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    // Waits for an edge at which hready is high, under a bounded count.
    task bus_wait;
        int n;
        n = 0;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                check("bus ready", 32'h1, 32'h0);
                print_verdict;
            end
            @(posedge clk_in);
        end
    endtask : bus_wait

    task bus(input logic [31:0] addr, input logic wr, input logic [31:0] data);
        haddr_in <= addr;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        hsize_in <= `HSIZE_WORD;
        bus_wait;
        htrans_in <= 2'h0;
        hwdata_in <= data;
        bus_wait;
    endtask : bus

    task wr(input logic [31:0] addr, input logic [31:0] data);
        bus(addr, 1'b1, data);
    endtask : wr

    task rc(input string what, input logic [31:0] addr, input logic [31:0] exp);
        bus(addr, 1'b0, 32'h0);
        check(what, exp, hrdata_out);
    endtask : rc

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial
    begin
        tick(3);
        rst_n_in <= 1'b1;
        hsel_in <= 1'b1;
        port_enable_in <= 1'b1;
        tick(3);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0);
        rc("pcr16", 32'h40, 32'h0);
        rc("unmapped", 32'h90, 32'h0);
        check("hresp", 32'h0, {31'h0, hresp_out});
        $display("test reset done");
        wr(32'h40, 32'h0009_0100);
        wr(`OFS_UPPER_BULK, 32'h8001_ffff);
        rc("pcr16", 32'h40, 32'h0009_0757);
        rc("pcr17", 32'h44, 32'h0);
        wr(32'h7c, 32'h000c_0757);
        rc("pcr31", 32'h7c, 32'h0000_0757);
        rc("upper bulk", `OFS_UPPER_BULK, 32'h0);
        wr(`OFS_LOWER_BULK, 32'h0004_0103);
        rc("pcr2", 32'h08, 32'h0000_0103);
        rc("lower bulk", `OFS_LOWER_BULK, 32'h0);
        wr(32'h0c, 32'h0000_0013);
        tick(3);
        check("pull en", 32'h8001_0004, pull_enable_out);
        check("filter", 32'h8001_0000, filter_enable_out);
        check("pull sel", 32'h8001_000c, pull_select_out);
        check("drive", 32'h8001_0000, drive_high_out);
        check("slew", 32'h8001_0000, slew_slow_out);
        check("mux", 32'h7701, {16'h0000, 1'b0, mux_select_out[95:93], 1'b0,
            mux_select_out[50:48], 5'h00, mux_select_out[8:6]});
        $display("test bulk done");
        level <= 32'h0001_0000;
        tick(6);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0001_0000);
        check("irq", 32'h1, irq_out);
        wr(`OFS_EVENT_FLAGS, 32'h0);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0001_0000);
        wr(`OFS_EVENT_FLAGS, 32'h0001_0000);
        tick(2);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0);
        check("irq", 32'h0, irq_out);
        $display("test edge done");
        wr(32'h44, 32'h000c_0100);
        level <= 32'h0003_0000;
        tick(6);
        rc("pcr17", 32'h44, 32'h010c_0100);
        wr(32'h44, 32'h010c_0100);
        tick(2);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0002_0000);
        level <= 32'h0001_0000;
        tick(6);
        wr(`OFS_EVENT_FLAGS, 32'h0002_0000);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0);
        $display("test level done");
        dma_delay <= 8'h0a;
        wr(32'h48, 32'h0003_0100);
        level <= 32'h0005_0000;
        tick(6);
        check("dma req", 32'h1, dma_req_out);
        check("irq", 32'h0, irq_out);
        tick(16);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0);
        check("dma req", 32'h0, dma_req_out);
        dma_delay <= 8'h00;
        $display("test dma done");
        port_enable_in <= 1'b0;
        wr(32'h4c, 32'h000a_0100);
        level <= 32'h000d_0000;
        tick(4);
        level <= 32'h0005_0000;
        tick(6);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0);
        rc("pcr19", 32'h4c, 32'h000a_0100);
        stop_mode_in <= 1'b1;
        port_enable_in <= 1'b1;
        level <= 32'h000d_0000;
        tick(4);
        level <= 32'h0005_0000;
        tick(3);
        check("wakeup", 32'h1, wakeup_out);
        rc("flags", `OFS_EVENT_FLAGS, 32'h0008_0000);
        stop_mode_in <= 1'b0;
        tick(3);
        check("wakeup", 32'h0, wakeup_out);
        wr(`OFS_EVENT_FLAGS, 32'h0008_0000);
        $display("test stop done");
        for (int i = 0; i < 10; i++)
            wr(32'h50 + 32'(4 * i), {12'h000, codes[i], 16'h0100});
        level <= 32'hbff5_0000;
        tick(6);
        level <= 32'h0005_0000;
        tick(6);
        rc("flags", `OFS_EVENT_FLAGS, 32'h1fe0_0000);
        check("irq", 32'h1, irq_out);
        check("dma req", 32'h1, dma_req_out);
        dma_delay <= 8'h03;
        tick(20);
        rc("flags", `OFS_EVENT_FLAGS, 32'h1f00_0000);
        check("dma req", 32'h0, dma_req_out);
        $display("test modes done");
        print_verdict;
    end
endmodule : port_pin_control_tb
